// ===== logic/timer_defs.vh
// Register offsets, field positions and reset values of the timer counter core.
// Assumes byte-wide registers reached over a plain address/strobe port.
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define ADDR_CAPTURE_OR_COMPARE 6'h00
`define ADDR_COUNTER_HIGH       6'h04
`define ADDR_COUNTER_LOW        6'h05
`define ADDR_SYSTEM_CONTROL_ONE 6'h06
`define ADDR_CHANNEL_IRQ_EN     6'h0c
`define ADDR_SYSTEM_CONTROL_TWO 6'h0d
`define ADDR_CHANNEL_FLAGS      6'h0e
`define ADDR_OVERFLOW_FLAG_REG  6'h0f
`define ADDR_CHANNEL_BASE       6'h10
`define ADDR_CHANNEL_LAST       6'h1f
`define ADDR_PULSE_ACCUM_CTRL   6'h20

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define BIT_TIMER_ENABLE        7
`define BIT_FAST_CLEAR          4
`define BIT_OVERFLOW_IRQ_EN     7
`define BIT_COUNTER_RESET_CH7   3
`define BIT_OVERFLOW_FLAG       7
`define BIT_PULSE_ACCUM_ENABLE  6
`define PRESCALER_MSB           2
`define PRESCALER_LSB           0

// ---------------------------------------------------------------------------
// Reset values and widths
// ---------------------------------------------------------------------------
`define RESET_BYTE              8'h00
`define RESET_CHANNEL_VALUE     16'h0000
`define COUNTER_MAX             16'hffff
`define PRESCALE_STAGES         7

`endif

// ===== logic/prescaler_divider.v
// Bus clock prescaler: a 7-stage counter that yields a one-cycle tick every
// 1..128 bus clocks. Assumes the parent samples tick on the same clock.
`timescale 1ns/1ps
`include "timer_defs.vh"

module prescaler_divider (
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire       run,
  input  wire       restart,
  input  wire [2:0] select,
  output wire       tick
);

  reg  [`PRESCALE_STAGES-1:0] count;
  reg  [2:0]                  active_select;
  wire [`PRESCALE_STAGES-1:0] mask;

  // ---------------------------------------------------------------------------
  // Division
  // ---------------------------------------------------------------------------

  // The low stages selected by the active code must all be ones for a tick.
  assign mask = ~({`PRESCALE_STAGES{1'b1}} << active_select);
  assign tick = run & ((count & mask) == mask); // [R7]

  // A new code is only adopted when every stage is about to be zero, so that
  // a division change never produces a short or stretched prescaler period.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count         <= {`PRESCALE_STAGES{1'b0}};
      active_select <= 3'h0;
    end else if (!run || restart) begin
      count         <= {`PRESCALE_STAGES{1'b0}};
      active_select <= select; // [R8]
    end else begin
      count <= count + 7'h01;
      if (count == {`PRESCALE_STAGES{1'b1}}) begin
        active_select <= select; // [R8]
      end
    end
  end

endmodule // prescaler_divider

// ===== logic/timer_counter_core_flags.v
// Sixteen-bit timer counter with prescaler, channel 7 modulus reset,
// overflow flag, eight capture/compare channels and their flags.
// Assumes a byte-wide register port on ref_clk and asynchronous capture pins.
//
// Operation
// [R1] Overflow interrupt request follows the overflow flag when its enable is set.
// [R2] Counter reset enable makes a channel 7 compare reset the counter.
// [R3] Reset enable with channel 7 value zero holds the counter at zero.
// [R4] Reset at channel 7 value 0xffff never sets the overflow flag.
// [R5] Modulus period is channel 7 value times division plus one clock.
// [R6] Without channel 7 the counter reset enable bit is reserved, reads zero.
// [R7] Prescaler select codes 0..7 divide the bus clock by 1..128.
// [R8] A new division takes effect only when all prescale stages are zero.
// [R9] A capture or compare event sets that channel's flag.
// [R10] Writing one clears a channel flag only while timer or accumulator enabled.
// [R11] Fast clear: capture read or compare write clears that channel's flag.
// [R12] Fast clear: any counter access clears the overflow flag register.
// [R13] Counter rollover from 0xffff to zero sets the overflow flag.
// [R14] Writing one to bit 7 clears overflow flag while timer or accumulator enabled.
// [R15] A capture channel latches the counter on a sensed input transition.
// [R16] A compare channel signals its output action when the counter reaches it.
// [R17] Writes to a channel in capture mode are ignored.
// [R18] Every channel register resets to zero.
// [R19] Software accesses the high byte of a channel before the low byte.
// [R20] An absent channel's register ignores writes and reads zero.
// [R21] Absent bits of the channel flag register ignore writes and read zero.
// [R22] Each channel interrupt request follows its flag when enabled.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "timer_defs.vh"

module timer_counter_core_flags #(
  parameter [7:0] CHANNEL_MASK = 8'hff
) (
  input  wire        ref_clk,
  input  wire        reset_n,
  input  wire [5:0]  address,
  input  wire [7:0]  write_data,
  input  wire        write_strobe,
  input  wire        read_strobe,
  input  wire [7:0]  capture_pin,
  output reg  [7:0]  read_data,
  output reg         overflow_irq,
  output reg  [7:0]  channel_irq,
  output reg  [7:0]  compare_event,
  output reg  [15:0] free_running_counter
);

  // ---------------------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------------------

  // True when the address falls in the channel register range.
  function is_channel_addr;
    input [5:0] a;
    begin
      is_channel_addr = (a >= `ADDR_CHANNEL_BASE) && (a <= `ADDR_CHANNEL_LAST);
    end
  endfunction

  // One-hot channel selected by a channel register address.
  function [7:0] channel_onehot;
    input [5:0] a;
    begin
      channel_onehot = is_channel_addr(a) ? (8'h01 << a[3:1]) : 8'h00;
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  reg  [7:0]  capture_or_compare_select;
  reg         timer_master_enable;
  reg         fast_flag_clear_select;
  reg         pulse_accum_enable;
  reg  [7:0]  channel_irq_enables;
  reg         overflow_irq_enable;
  reg         counter_reset_on_ch7;
  reg  [2:0]  prescaler_select;
  reg  [7:0]  channel_flags;
  reg         overflow_flag;
  reg  [15:0] capture_compare_value [0:7];
  reg  [7:0]  write_high_buffer;
  reg  [7:0]  read_low_buffer;
  reg         pending_reset;
  reg  [7:0]  pin_meta;
  reg  [7:0]  pin_sync;
  reg  [7:0]  pin_last;
  reg  [7:0]  next_read_data;
  reg  [7:0]  next_low_buffer;

  wire        tick;
  wire        clear_allowed;
  wire        write_hit_flags;
  wire        counter_access;
  wire [7:0]  channel_sel;
  wire [7:0]  capture_hit;
  wire [7:0]  compare_hit;
  wire [7:0]  fast_clear;
  wire [7:0]  flag_clear;
  wire [7:0]  next_channel_flags;
  wire [15:0] counter_plus_one;
  wire        hold_at_zero;
  wire        overflow_hit;
  wire        next_overflow_flag;

  // ---------------------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------------------

  // The prescaler is restarted by a modulus reset so that the next counter
  // cycle starts on a whole prescaler period.
  prescaler_divider prescaler (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .run     (timer_master_enable),
    .restart (pending_reset),
    .select  (prescaler_select),
    .tick    (tick)
  );

  // ---------------------------------------------------------------------------
  // Capture pin synchronisers and edge detection
  // ---------------------------------------------------------------------------

  // Two flip-flops before any logic; the third stage only serves edge detection.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
      pin_last <= 8'h00;
    end else begin
      pin_meta <= capture_pin;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // A rising synchronised transition on a capture channel is a capture event.
  assign capture_hit = pin_sync & ~pin_last & ~capture_or_compare_select & CHANNEL_MASK;

  // ---------------------------------------------------------------------------
  // Shared decode
  // ---------------------------------------------------------------------------
  assign clear_allowed   = timer_master_enable | pulse_accum_enable;
  assign write_hit_flags = write_strobe && (address == `ADDR_CHANNEL_FLAGS);
  assign counter_access  = (write_strobe | read_strobe) &&
                           ((address == `ADDR_COUNTER_HIGH) ||
                            (address == `ADDR_COUNTER_LOW));
  assign channel_sel     = channel_onehot(address) & CHANNEL_MASK;
  assign counter_plus_one = free_running_counter + 16'h0001;
  assign hold_at_zero    = counter_reset_on_ch7 &&
                           (capture_compare_value[7] == `RESET_CHANNEL_VALUE);

  // ---------------------------------------------------------------------------
  // Free-running counter
  // ---------------------------------------------------------------------------

  // Rollover only counts when the counter itself wraps; a modulus reset to
  // zero goes through pending_reset and never raises the overflow flag.
  assign overflow_hit = timer_master_enable && !pending_reset && !hold_at_zero && tick &&
                        (free_running_counter == `COUNTER_MAX); // [R13] [R4]

  // The modulus reset takes one extra bus clock after the match tick, which
  // gives a period of the channel 7 value times the division plus one clock.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      free_running_counter <= `RESET_CHANNEL_VALUE;
      pending_reset        <= 1'b0;
    end else if (!timer_master_enable) begin
      pending_reset        <= 1'b0;
    end else if (pending_reset) begin
      free_running_counter <= `RESET_CHANNEL_VALUE; // [R2] [R5]
      pending_reset        <= 1'b0;
    end else if (hold_at_zero) begin
      free_running_counter <= `RESET_CHANNEL_VALUE; // [R3]
    end else if (tick) begin
      free_running_counter <= counter_plus_one;
      pending_reset        <= counter_reset_on_ch7 &&
                              (counter_plus_one == capture_compare_value[7]); // [R2] [R5]
    end
  end

  // ---------------------------------------------------------------------------
  // Capture/compare channels
  // ---------------------------------------------------------------------------

  // Compare fires on the tick that brings the counter onto the channel value.
  genvar ch;
  generate
    for (ch = 0; ch < 8; ch = ch + 1) begin : channel
      assign compare_hit[ch] = CHANNEL_MASK[ch] && capture_or_compare_select[ch] &&
                               timer_master_enable && tick && !pending_reset &&
                               !hold_at_zero &&
                               (counter_plus_one == capture_compare_value[ch]); // [R16]

      // Capture has the register in capture mode, software in compare mode.
      always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          capture_compare_value[ch] <= `RESET_CHANNEL_VALUE; // [R18]
        end else if (!CHANNEL_MASK[ch]) begin
          capture_compare_value[ch] <= `RESET_CHANNEL_VALUE; // [R20]
        end else if (capture_hit[ch]) begin
          capture_compare_value[ch] <= free_running_counter; // [R15]
        end else if (write_strobe && channel_sel[ch] && address[0] &&
                     capture_or_compare_select[ch]) begin
          capture_compare_value[ch] <= {write_high_buffer, write_data}; // [R17]
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Channel flags
  // ---------------------------------------------------------------------------

  // Fast clear: a read of a capture channel or a write of a compare channel.
  assign fast_clear = fast_flag_clear_select ?
                      ((read_strobe  ? channel_sel & ~capture_or_compare_select : 8'h00) |
                       (write_strobe ? channel_sel &  capture_or_compare_select : 8'h00))
                      : 8'h00; // [R11]

  assign flag_clear = ((write_hit_flags && clear_allowed) ? write_data : 8'h00) // [R10]
                      | fast_clear;

  // An event in the same cycle as its clear keeps the flag set.
  assign next_channel_flags = ((channel_flags & ~flag_clear) | capture_hit | compare_hit)
                              & CHANNEL_MASK; // [R9] [R21]

  assign next_overflow_flag =
    (overflow_flag &
     ~((write_strobe && (address == `ADDR_OVERFLOW_FLAG_REG) && clear_allowed &&
        write_data[`BIT_OVERFLOW_FLAG]) || // [R14]
       (fast_flag_clear_select && counter_access))) // [R12]
    | overflow_hit;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      channel_flags <= `RESET_BYTE;
      overflow_flag <= 1'b0;
    end else begin
      channel_flags <= next_channel_flags;
      overflow_flag <= next_overflow_flag;
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------

  // Software-written controls; the counter reset enable is forced to zero
  // when channel 7 is absent so it neither stores nor reads back.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      capture_or_compare_select <= `RESET_BYTE;
      timer_master_enable       <= 1'b0;
      fast_flag_clear_select    <= 1'b0;
      pulse_accum_enable        <= 1'b0;
      channel_irq_enables       <= `RESET_BYTE;
      overflow_irq_enable       <= 1'b0;
      counter_reset_on_ch7      <= 1'b0;
      prescaler_select          <= 3'h0;
      write_high_buffer         <= `RESET_BYTE;
    end else if (write_strobe) begin
      case (address)
        `ADDR_CAPTURE_OR_COMPARE: begin
          capture_or_compare_select <= write_data & CHANNEL_MASK;
        end
        `ADDR_SYSTEM_CONTROL_ONE: begin
          timer_master_enable    <= write_data[`BIT_TIMER_ENABLE];
          fast_flag_clear_select <= write_data[`BIT_FAST_CLEAR];
        end
        `ADDR_CHANNEL_IRQ_EN: begin
          channel_irq_enables <= write_data & CHANNEL_MASK;
        end
        `ADDR_SYSTEM_CONTROL_TWO: begin
          overflow_irq_enable  <= write_data[`BIT_OVERFLOW_IRQ_EN];
          counter_reset_on_ch7 <= write_data[`BIT_COUNTER_RESET_CH7] &
                                  CHANNEL_MASK[7]; // [R6]
          prescaler_select     <= write_data[`PRESCALER_MSB:`PRESCALER_LSB]; // [R7]
        end
        `ADDR_PULSE_ACCUM_CTRL: begin
          pulse_accum_enable <= write_data[`BIT_PULSE_ACCUM_ENABLE];
        end
        default: begin
          // High byte of a channel is held until its low byte completes the word.
          if (is_channel_addr(address) && !address[0]) begin
            write_high_buffer <= write_data; // [R19]
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------

  // Reading a high byte freezes its low byte, so a high-then-low pair is
  // coherent; the reverse order may mix two different counter values.
  always @* begin
    next_read_data  = 8'h00;
    next_low_buffer = read_low_buffer;
    case (address)
      `ADDR_CAPTURE_OR_COMPARE: next_read_data = capture_or_compare_select;
      `ADDR_COUNTER_HIGH: begin
        next_read_data  = free_running_counter[15:8];
        next_low_buffer = free_running_counter[7:0];
      end
      `ADDR_COUNTER_LOW: next_read_data = read_low_buffer;
      `ADDR_SYSTEM_CONTROL_ONE: begin
        next_read_data[`BIT_TIMER_ENABLE] = timer_master_enable;
        next_read_data[`BIT_FAST_CLEAR]   = fast_flag_clear_select;
      end
      `ADDR_CHANNEL_IRQ_EN: next_read_data = channel_irq_enables;
      `ADDR_SYSTEM_CONTROL_TWO: begin
        next_read_data[`BIT_OVERFLOW_IRQ_EN]   = overflow_irq_enable;
        next_read_data[`BIT_COUNTER_RESET_CH7] = counter_reset_on_ch7; // [R6]
        next_read_data[`PRESCALER_MSB:`PRESCALER_LSB] = prescaler_select;
      end
      `ADDR_CHANNEL_FLAGS: next_read_data = channel_flags; // [R21]
      `ADDR_OVERFLOW_FLAG_REG: next_read_data[`BIT_OVERFLOW_FLAG] = overflow_flag;
      `ADDR_PULSE_ACCUM_CTRL: next_read_data[`BIT_PULSE_ACCUM_ENABLE] = pulse_accum_enable;
      default: begin
        if (is_channel_addr(address)) begin
          if (!address[0]) begin
            next_read_data  = capture_compare_value[address[3:1]][15:8]; // [R20]
            next_low_buffer = capture_compare_value[address[3:1]][7:0];
          end else begin
            next_read_data  = read_low_buffer & {8{CHANNEL_MASK[address[3:1]]}};
          end
        end
      end
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_data       <= 8'h00;
      read_low_buffer <= 8'h00;
    end else begin
      read_data <= read_strobe ? next_read_data : 8'h00;
      if (read_strobe) begin
        read_low_buffer <= next_low_buffer;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Requests and output actions
  // ---------------------------------------------------------------------------

  // Requests are levels that follow the registered flags by one clock.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      overflow_irq  <= 1'b0;
      channel_irq   <= 8'h00;
      compare_event <= 8'h00;
    end else begin
      overflow_irq  <= overflow_flag & overflow_irq_enable; // [R1]
      channel_irq   <= channel_flags & channel_irq_enables; // [R22]
      compare_event <= compare_hit; // [R16]
    end
  end

endmodule // timer_counter_core_flags

// ===== test/timer_counter_core_flags_checker.sv
// Port-level checker for the timer counter core.
// Assumes it is bound to timer_counter_core_flags with the same channel mask.
`timescale 1ns/1ps

module timer_counter_core_flags_checker #(
  parameter [7:0] CHANNEL_MASK = 8'hff
) (
  input wire        ref_clk,
  input wire        reset_n,
  input wire [5:0]  address,
  input wire [7:0]  write_data,
  input wire        write_strobe,
  input wire        read_strobe,
  input wire [7:0]  capture_pin,
  input wire [7:0]  read_data,
  input wire        overflow_irq,
  input wire [7:0]  channel_irq,
  input wire [7:0]  compare_event,
  input wire [15:0] free_running_counter
);
  // ---------------------------------------------------------------------------
  // Relations between the ports
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // High when the address falls on a channel that this build leaves out.
  wire absent_sel = (address[5:4] == 2'b01) && !CHANNEL_MASK[address[3:1]];

  property p_idle_read; !read_strobe |=> read_data == 8'h00; endproperty
  a_idle_read: assert property (p_idle_read) else $error("read data without a read");
  property p_unmapped; read_strobe && address > 6'h20 |=> read_data == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_absent_read; read_strobe && absent_sel |=> read_data == 8'h00; endproperty
  a_absent_read: assert property (p_absent_read) else $error("absent channel read");
  property p_flag_bits; read_strobe && address == 6'h0e |=> (read_data & ~CHANNEL_MASK) == 8'h00;
  endproperty
  a_flag_bits: assert property (p_flag_bits) else $error("absent flag bit set");
  property p_absent_out; ((channel_irq | compare_event) & ~CHANNEL_MASK) == 8'h00; endproperty
  a_absent_out: assert property (p_absent_out) else $error("absent channel active");
  property p_count_step;
    free_running_counter == $past(free_running_counter) ||
    free_running_counter == $past(free_running_counter) + 16'h0001 ||
    free_running_counter == 16'h0000;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter jumped");
  property p_event_pulse; |compare_event |=> (compare_event & $past(compare_event)) == 8'h00;
  endproperty
  a_event_pulse: assert property (p_event_pulse) else $error("compare event too long");
  property p_count_read;
    read_strobe && address == 6'h04 |=> read_data == $past(free_running_counter[15:8]);
  endproperty
  a_count_read: assert property (p_count_read) else $error("counter high byte wrong");
endmodule // timer_counter_core_flags_checker

bind timer_counter_core_flags timer_counter_core_flags_checker #(
  .CHANNEL_MASK(CHANNEL_MASK)
) u_checker (
  .ref_clk(ref_clk), .reset_n(reset_n), .address(address), .write_data(write_data),
  .write_strobe(write_strobe), .read_strobe(read_strobe), .capture_pin(capture_pin),
  .read_data(read_data), .overflow_irq(overflow_irq), .channel_irq(channel_irq),
  .compare_event(compare_event), .free_running_counter(free_running_counter)
);

// ===== test/test_timer_counter_core_flags.sv
// Self-checking bench for the timer counter core over its register port.
// Assumes the register map of timer_defs.vh; channel 6 is built absent.
`timescale 1ns/1ps
`include "timer_defs.vh"

module test_timer_counter_core_flags;
  reg         ref_clk = 1'b0;
  reg         reset_n = 1'b0;
  reg  [5:0]  address = 6'h00;
  reg  [7:0]  write_data = 8'h00;
  reg         write_strobe = 1'b0;
  reg         read_strobe = 1'b0;
  reg  [7:0]  capture_pin = 8'h00;
  wire [7:0]  read_data;
  wire        overflow_irq;
  wire [7:0]  channel_irq;
  wire [7:0]  compare_event;
  wire [15:0] free_running_counter;
  integer     n_errors = 0;
  integer     n_compared = 0;
  integer     i;
  reg  [15:0] cycles = 16'h0000;
  reg  [15:0] t0;
  reg  [7:0]  rv;
  reg  [15:0] wv;

  timer_counter_core_flags #(.CHANNEL_MASK(8'hbf)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .capture_pin(capture_pin),
    .read_data(read_data), .overflow_irq(overflow_irq), .channel_irq(channel_irq),
    .compare_event(compare_event), .free_running_counter(free_running_counter)
  );

  // ---------------------------------------------------------------------------
  // Clock, cycle count and access tasks
  // ---------------------------------------------------------------------------
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cycles <= cycles + 16'h0001;

  function [5:0] ch_addr(input integer c);
    ch_addr = `ADDR_CHANNEL_BASE + c[5:0] * 6'h02;
  endfunction

  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // The strobe stands one edge; calls in a row leave a gap.
  task wr(input [5:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge ref_clk);
      write_strobe <= 1'b0;
    end
  endtask

  task rd(input [5:0] a);
    begin
      @(posedge ref_clk);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge ref_clk);
      read_strobe <= 1'b0;
      #1;
      rv = read_data;
    end
  endtask

  // Words go high byte first.
  task wr16(input [5:0] a, input [15:0] d);
    begin
      wr(a, d[15:8]);
      wr(a + 6'h01, d[7:0]);
    end
  endtask

  task rd16(input [5:0] a);
    begin
      rd(a);
      wv[15:8] = rv;
      rd(a + 6'h01);
      wv[7:0] = rv;
    end
  endtask

  task wait_ev(input integer ch);
    integer k;
    begin
      k = 0;
      @(posedge ref_clk);
      #1;
      while (compare_event[ch] !== 1'b1 && k < 5000) begin
        @(posedge ref_clk);
        #1;
        k = k + 1;
      end
      chk({15'h0000, compare_event[ch]}, 16'h0001);
    end
  endtask

  task end_sim;
    begin
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask

  // ---------------------------------------------------------------------------
  // Watchdog: the overflow wait alone needs about 65536 cycles.
  // ---------------------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_errors = n_errors + 1;
    end_sim;
  end

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`ADDR_SYSTEM_CONTROL_TWO);
    chk({8'h00, rv}, 16'h0000);
    rd(6'h3f);
    chk({8'h00, rv}, 16'h0000);
    for (i = 0; i < 8; i = i + 1) begin
      rd16(ch_addr(i));
      chk(wv, 16'h0000);
    end
    // Channel 0 captures; capture and absent channels refuse writes.
    wr(`ADDR_CAPTURE_OR_COMPARE, 8'hfe);
    wr16(ch_addr(0), 16'h1234);
    rd16(ch_addr(0));
    chk(wv, 16'h0000);
    wr16(ch_addr(6), 16'h5555);
    rd16(ch_addr(6));
    chk(wv, 16'h0000);
    // Modulus at zero with the timer running keeps the counter at zero.
    wr(`ADDR_SYSTEM_CONTROL_TWO, 8'h08);
    wr(`ADDR_SYSTEM_CONTROL_ONE, 8'h80);
    for (i = 0; i < 20; i = i + 1) begin
      @(posedge ref_clk);
      #1;
      chk(free_running_counter, 16'h0000);
    end
    wr(`ADDR_SYSTEM_CONTROL_ONE, 8'h00);
    // A capture with the timer off; clearing is refused until it is enabled.
    capture_pin <= 8'h01;
    repeat (5) @(posedge ref_clk);
    rd(`ADDR_CHANNEL_FLAGS);
    chk({8'h00, rv}, 16'h0001);
    wr(`ADDR_CHANNEL_FLAGS, 8'h01);
    rd(`ADDR_CHANNEL_FLAGS);
    chk({8'h00, rv}, 16'h0001);
    capture_pin <= 8'h00;
    wr(`ADDR_SYSTEM_CONTROL_TWO, 8'h07);
    wr16(ch_addr(1), 16'h0002);
    wr(`ADDR_SYSTEM_CONTROL_ONE, 8'h80);
    wr(`ADDR_CHANNEL_FLAGS, 8'h00);
    rd(`ADDR_CHANNEL_FLAGS);
    chk({8'h00, rv}, 16'h0001);
    wr(`ADDR_CHANNEL_FLAGS, 8'hff);
    rd(`ADDR_CHANNEL_FLAGS);
    chk({8'h00, rv}, 16'h0000);
    // At divide by 128 the counter rests at 2 long enough to capture it.
    wait_ev(1);
    rd16(`ADDR_COUNTER_HIGH);
    chk(wv, 16'h0002);
    capture_pin <= 8'h01;
    repeat (5) @(posedge ref_clk);
    rd16(ch_addr(0));
    chk(wv, 16'h0002);
    rd(`ADDR_CHANNEL_FLAGS);
    chk({8'h00, rv}, 16'h0003);
    wr(`ADDR_CHANNEL_IRQ_EN, 8'h02);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({8'h00, channel_irq}, 16'h0002);
    // Fast clearing: capture read and compare write clear their flags.
    wr(`ADDR_SYSTEM_CONTROL_ONE, 8'h90);
    rd16(ch_addr(0));
    wr16(ch_addr(1), 16'h0002);
    rd(`ADDR_CHANNEL_FLAGS);
    chk({8'h00, rv}, 16'h0000);
    #1;
    chk({8'h00, channel_irq}, 16'h0000);
    wr(`ADDR_SYSTEM_CONTROL_ONE, 8'h80);
    capture_pin <= 8'h00;
    // Modulus 16 period for every prescaler code.
    wr16(ch_addr(7), 16'h0010);
    for (i = 0; i < 8; i = i + 1) begin
      wr(`ADDR_SYSTEM_CONTROL_TWO, 8'h08 | i[7:0]);
      wait_ev(7);
      wait_ev(7);
      t0 = cycles;
      wait_ev(7);
      chk(cycles - t0, (16'h0010 << i) + 16'h0001);
    end
    // Free run at divide by 1 until rollover.
    wr(`ADDR_SYSTEM_CONTROL_TWO, 8'h80);
    i = 0;
    while (overflow_irq !== 1'b1 && i < 70000) begin
      @(posedge ref_clk);
      #1;
      i = i + 1;
    end
    chk({15'h0000, overflow_irq}, 16'h0001);
    rd(`ADDR_OVERFLOW_FLAG_REG);
    chk({8'h00, rv}, 16'h0080);
    wr(`ADDR_SYSTEM_CONTROL_TWO, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({15'h0000, overflow_irq}, 16'h0000);
    wr(`ADDR_OVERFLOW_FLAG_REG, 8'h80);
    rd(`ADDR_OVERFLOW_FLAG_REG);
    chk({8'h00, rv}, 16'h0000);
    end_sim;
  end
endmodule // test_timer_counter_core_flags
